// ==== common/sgr_pkg.sv ====
// Constants shared by the switch global register bank and its users.
// Assumes a byte-wide management access port driven by the host interface logic.
package sgr_pkg;

  // Address and data widths of the byte access port.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Address field positions: port, page, register within page.
  localparam int PORT_HI = 14;
  localparam int PORT_LO = 12;
  localparam int PAGE_HI = 11;
  localparam int PAGE_LO = 8;
  localparam int REG_HI  = 7;
  localparam int REG_LO  = 0;

  // Port field value for the global space.
  localparam logic [2:0] PORT_GLOBAL = 3'h0;

  // Global pages.
  localparam logic [3:0] PAGE_OPERATION   = 4'h0;
  localparam logic [3:0] PAGE_GLOBAL_PHY  = 4'h2;
  localparam logic [3:0] PAGE_GLOBAL_LAST = 4'h4;

  // Port pages.
  localparam logic [3:0]  PAGE_PORT_PHY  = 4'h1;
  localparam logic [15:0] PORT_PAGE_RSVD = 16'hf084;

  // Byte offsets inside the operation control page.
  localparam logic [7:0] OFS_IDENT_0     = 8'h00;
  localparam logic [7:0] OFS_IDENT_HIGH  = 8'h01;
  localparam logic [7:0] OFS_IDENT_LOW   = 8'h02;
  localparam logic [7:0] OFS_REV_SOFTRST = 8'h03;
  localparam logic [7:0] OFS_PWR_EVENT   = 8'h06;
  localparam logic [7:0] OFS_INT_STATUS  = 8'h10;
  localparam logic [7:0] OFS_INT_MASK    = 8'h14;

  // Field positions.
  localparam int SOFTRST_BIT    = 0;
  localparam int PWR_EN_BIT     = 1;
  localparam int PWR_POL_BIT    = 0;
  localparam int LOOKUP_INT_BIT = 31;

  // Values after reset.
  localparam logic SOFTRST_RST  = 1'b0;
  localparam logic PWR_EN_RST   = 1'b0;
  localparam logic PWR_POL_RST  = 1'b0;
  localparam logic INT_MASK_RST = 1'b0;
  localparam logic INT_STAT_RST = 1'b0;

  // Classes of an address seen from the requesting management path.
  typedef enum logic [1:0] {
    SGR_RG_LOCAL = 2'h0,
    SGR_RG_FWD   = 2'h1,
    SGR_RG_RSVD  = 2'h2,
    SGR_RG_DENY  = 2'h3
  } sgr_region_t;

  // Access sequencer states.
  typedef enum logic [1:0] {
    SGR_ST_IDLE = 2'b01,
    SGR_ST_FWD  = 2'b10
  } sgr_state_t;

endpackage

// ==== logic/sgr_bank.sv ====
// Global register bank of the switch: byte access decode, page forwarding and the
// operation control registers. Assumes a host management path issuing one byte access
// at a time, and page blocks outside that answer forwarded accesses with a strobe.
//
// Notes on behaviour
// - Host path reaches all registers; serial PHY path reaches only PHY pages.
// - Address splits into 3-bit port, 4-bit page, 8-bit register fields.
// - Port field zero selects the global register space.
// - Port field one to seven selects that port's register space.
// - Address bit 15 is always zero; decoder ignores it.
// - Registers are byte addressed; single bytes accepted in any order.
// - Multi-byte registers are big-endian: MSB at lowest byte address.
// - Global pages: 0 operation, 1 I/O, 2 PHY, 3 switch, 4 lookup; rest reserved.
// - Port pages 0,1,3,4,5,6,8,9,A,B used; 2, 7 and C-F reserved.
// - Offsets 0 to 2 read fixed identification bytes.
// - Offset 3 bits 7:4 read the silicon revision code.
// - Offset 3 bit 0 holds data path in soft reset; never self-clears.
// - Power-event pin is driven only while offset 6 bit 1 is set.
// - Offset 6 bit 0 selects power-event pin level; zero means active low.
// - Status bit 31 at 0x10 mirrors the lookup engine interrupt request.
// - Mask bit 31 at 0x14 disables the lookup engine interrupt when one.
`timescale 1ns/100ps
module sgr_bank
  import sgr_pkg::*;
#(
  parameter logic [7:0] IDENT_0    = 8'h5a, // Arbitrary value.
  parameter logic [7:0] IDENT_HIGH = 8'h3c, // Arbitrary value.
  parameter logic [7:0] IDENT_LOW  = 8'h21, // Arbitrary value.
  parameter logic [3:0] REVISION   = 4'h1   // Arbitrary value.
)
(
  // Clock and reset.
  input  wire logic                        i_clock,
  input  wire logic                        i_rst,
  // Byte access port from the management paths.
  input  wire logic                        i_req,
  input  wire logic                        i_write,
  input  wire logic                        i_from_phy_serial,
  input  wire logic [sgr_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [sgr_pkg::DATA_W-1:0]  i_wdata,
  output logic                             o_ack,
  output logic                             o_err,
  output logic                             o_busy,
  output logic      [sgr_pkg::DATA_W-1:0]  o_rdata,
  // Forwarded access to the other register pages.
  output logic                             o_fwd_req,
  output logic                             o_fwd_write,
  output logic      [sgr_pkg::ADDR_W-1:0]  o_fwd_addr,
  output logic      [sgr_pkg::DATA_W-1:0]  o_fwd_wdata,
  input  wire logic                        i_fwd_ack,
  input  wire logic [sgr_pkg::DATA_W-1:0]  i_fwd_rdata,
  // Core events and controls.
  input  wire logic                        i_lookup_engine_irq,
  input  wire logic                        i_power_event,
  output logic                             o_soft_reset,
  output logic                             o_power_event_pin_out,
  output logic                             o_power_event_pin_oe,
  output logic                             o_irq
);
  import sgr_pkg::*;

  typedef struct packed {
    sgr_state_t               state;
    logic                     ack;
    logic                     err;
    logic [DATA_W-1:0]        rdata;
    logic                     fwd_req;
    logic                     fwd_write;
    logic [ADDR_W-1:0]        fwd_addr;
    logic [DATA_W-1:0]        fwd_wdata;
    logic                     soft_rst;
    logic                     pwr_en;
    logic                     pwr_pol;
    logic                     pwr_out;
    logic                     pwr_oe;
    logic                     int_mask;
    logic                     int_stat;
    logic                     irq;
  } sgr_regs_t;

  sgr_regs_t   s_r;
  sgr_regs_t   s_nxt;
  sgr_region_t region;

  // Classifies an address for the path that issued it. Bit 15 is never looked at.
  function automatic sgr_region_t classify(input logic [ADDR_W-1:0] addr,
                                           input logic              phy_serial);
    logic [2:0] port;
    logic [3:0] page;
    port = addr[PORT_HI:PORT_LO];
    page = addr[PAGE_HI:PAGE_LO];
    if (port == PORT_GLOBAL)
    begin
      if (page > PAGE_GLOBAL_LAST)
        classify = SGR_RG_RSVD;
      else if (phy_serial && page != PAGE_GLOBAL_PHY)
        classify = SGR_RG_DENY;
      else if (page == PAGE_OPERATION)
        classify = SGR_RG_LOCAL;
      else
        classify = SGR_RG_FWD;
    end
    else
    begin
      if (PORT_PAGE_RSVD[page])
        classify = SGR_RG_RSVD;
      else if (phy_serial && page != PAGE_PORT_PHY)
        classify = SGR_RG_DENY;
      else
        classify = SGR_RG_FWD;
    end
  endfunction

  // Picks one byte of a 32-bit register; the lowest byte address holds the top byte.
  function automatic logic [7:0] word_byte(input logic [31:0] word,
                                           input logic [1:0]  idx);
    case (idx)
      2'h0:    word_byte = word[31:24];
      2'h1:    word_byte = word[23:16];
      2'h2:    word_byte = word[15:8];
      default: word_byte = word[7:0];
    endcase
  endfunction

  assign region = classify(i_addr, i_from_phy_serial);

  always_comb
  begin
    logic [7:0]  ofs;
    logic [31:0] stat_word;
    logic [31:0] mask_word;
    ofs       = i_addr[REG_HI:REG_LO];
    stat_word = {s_r.int_stat, 31'h0};
    mask_word = {s_r.int_mask, 31'h0};
    s_nxt         = s_r;
    s_nxt.ack     = 1'b0;
    s_nxt.err     = 1'b0;
    s_nxt.fwd_req = 1'b0;
    s_nxt.int_stat = i_lookup_engine_irq;
    s_nxt.irq      = s_r.int_stat & ~s_r.int_mask;
    s_nxt.pwr_oe   = s_r.pwr_en;
    // Asserted level follows the polarity bit; idle level is its opposite.
    s_nxt.pwr_out  = s_r.pwr_pol ? i_power_event : ~i_power_event;
    case (s_r.state)
      SGR_ST_IDLE:
      begin
        if (i_req)
        begin
          case (region)
            SGR_RG_LOCAL:
            begin
              // Every byte stands alone, so any order of bytes is accepted.
              s_nxt.ack   = 1'b1;
              s_nxt.rdata = 8'h00;
              case (ofs)
                OFS_IDENT_0:     s_nxt.rdata = IDENT_0;
                OFS_IDENT_HIGH:  s_nxt.rdata = IDENT_HIGH;
                OFS_IDENT_LOW:   s_nxt.rdata = IDENT_LOW;
                OFS_REV_SOFTRST: s_nxt.rdata = {REVISION, 3'h0, s_r.soft_rst};
                OFS_PWR_EVENT:   s_nxt.rdata = {6'h00, s_r.pwr_en, s_r.pwr_pol};
                default:
                begin
                  if (ofs[7:2] == OFS_INT_STATUS[7:2])
                    s_nxt.rdata = word_byte(stat_word, ofs[1:0]);
                  else if (ofs[7:2] == OFS_INT_MASK[7:2])
                    s_nxt.rdata = word_byte(mask_word, ofs[1:0]);
                  else
                    s_nxt.rdata = 8'h00;
                end
              endcase
              if (i_write)
              begin
                s_nxt.rdata = 8'h00;
                // Read-only bits ignore writes, which keeps read-OR-write updates safe.
                case (ofs)
                  OFS_REV_SOFTRST: s_nxt.soft_rst = i_wdata[SOFTRST_BIT];
                  OFS_PWR_EVENT:
                  begin
                    s_nxt.pwr_en  = i_wdata[PWR_EN_BIT];
                    s_nxt.pwr_pol = i_wdata[PWR_POL_BIT];
                  end
                  OFS_INT_MASK:    s_nxt.int_mask = i_wdata[7];
                  default:         s_nxt.int_mask = s_r.int_mask;
                endcase
              end
            end
            SGR_RG_FWD:
            begin
              s_nxt.fwd_req   = 1'b1;
              s_nxt.fwd_write = i_write;
              s_nxt.fwd_addr  = {1'b0, i_addr[ADDR_W-2:0]};
              s_nxt.fwd_wdata = i_wdata;
              s_nxt.state     = SGR_ST_FWD;
            end
            default:
            begin
              // Reserved or out-of-reach space: writes are dropped, reads give zero.
              s_nxt.ack   = 1'b1;
              s_nxt.err   = 1'b1;
              s_nxt.rdata = 8'h00;
            end
          endcase
        end
      end
      SGR_ST_FWD:
      begin
        if (i_fwd_ack)
        begin
          s_nxt.ack   = 1'b1;
          s_nxt.rdata = s_r.fwd_write ? 8'h00 : i_fwd_rdata;
          s_nxt.state = SGR_ST_IDLE;
        end
      end
      default: s_nxt.state = SGR_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_r           <= '0;
      s_r.state     <= SGR_ST_IDLE;
      s_r.soft_rst  <= SOFTRST_RST;
      s_r.pwr_en    <= PWR_EN_RST;
      s_r.pwr_pol   <= PWR_POL_RST;
      s_r.int_mask  <= INT_MASK_RST;
      s_r.int_stat  <= INT_STAT_RST;
      // Disabled pin with active-low polarity idles high.
      s_r.pwr_out   <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign o_ack                 = s_r.ack;
  assign o_err                 = s_r.err;
  assign o_busy                = s_r.state[1];
  assign o_rdata               = s_r.rdata;
  assign o_fwd_req             = s_r.fwd_req;
  assign o_fwd_write           = s_r.fwd_write;
  assign o_fwd_addr            = s_r.fwd_addr;
  assign o_fwd_wdata           = s_r.fwd_wdata;
  assign o_soft_reset          = s_r.soft_rst;
  assign o_power_event_pin_out = s_r.pwr_out;
  assign o_power_event_pin_oe  = s_r.pwr_oe;
  assign o_irq                 = s_r.irq;

  property p_ident_read;
    @(posedge i_clock) disable iff (i_rst)
    (i_req && !o_busy && !i_write && region == SGR_RG_LOCAL && i_addr[7:0] == OFS_IDENT_HIGH)
      |=> (o_ack && o_rdata == IDENT_HIGH);
  endproperty
  a_ident_read: assert property (p_ident_read) else $error("ident byte wrong");

  property p_rev_read;
    @(posedge i_clock) disable iff (i_rst)
    (i_req && !o_busy && !i_write && region == SGR_RG_LOCAL && i_addr[7:0] == OFS_REV_SOFTRST)
      |=> (o_rdata[7:4] == REVISION && o_rdata[0] == $past(o_soft_reset));
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("revision byte wrong");

  property p_softrst_hold;
    @(posedge i_clock) disable iff (i_rst)
    (o_soft_reset && !(i_req && i_write && region == SGR_RG_LOCAL)) |=> o_soft_reset;
  endproperty
  a_softrst_hold: assert property (p_softrst_hold) else $error("soft reset cleared");

  property p_pin_enable;
    @(posedge i_clock) disable iff (i_rst)
    !s_r.pwr_en [*2] |-> !o_power_event_pin_oe;
  endproperty
  a_pin_enable: assert property (p_pin_enable) else $error("pin driven while off");

  property p_pin_level;
    @(posedge i_clock) disable iff (i_rst)
    $stable(s_r.pwr_pol) |=> (o_power_event_pin_out == ($past(s_r.pwr_pol) ~^ $past(i_power_event)));
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level wrong");

  property p_status_read;
    @(posedge i_clock) disable iff (i_rst)
    (i_req && !o_busy && !i_write && region == SGR_RG_LOCAL && i_addr[7:0] == OFS_INT_STATUS)
      |=> (o_rdata == {$past(s_r.int_stat), 7'h00});
  endproperty
  a_status_read: assert property (p_status_read) else $error("status byte wrong");

  property p_irq_out;
    @(posedge i_clock) disable iff (i_rst)
    (i_lookup_engine_irq && !s_r.int_mask) ##1 !s_r.int_mask |=> o_irq;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("irq not raised");

  property p_irq_masked;
    @(posedge i_clock) disable iff (i_rst)
    s_r.int_mask |=> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked irq seen");

  property p_phy_deny;
    @(posedge i_clock) disable iff (i_rst)
    (i_req && !o_busy && i_from_phy_serial && i_addr[PAGE_HI:PAGE_LO] == PAGE_OPERATION)
      |=> (o_ack && o_err && !o_fwd_req);
  endproperty
  a_phy_deny: assert property (p_phy_deny) else $error("serial path reached switch");

  property p_rsvd_drop;
    @(posedge i_clock) disable iff (i_rst)
    (i_req && !o_busy && i_addr[PORT_HI:PORT_LO] != PORT_GLOBAL
     && i_addr[PAGE_HI:PAGE_LO] == 4'h7) |=> (!o_fwd_req && o_err);
  endproperty
  a_rsvd_drop: assert property (p_rsvd_drop) else $error("reserved page forwarded");

endmodule

// ==== test/sgr_page_model.sv ====
// Behavioural page block that answers accesses forwarded by the global bank.
// Assumes the bank holds the forward fields from its strobe until the answer.
`timescale 1ns/100ps
module sgr_page_model
  import sgr_pkg::*;
(
  // Clock and reset.
  input  wire logic                       i_clock,
  input  wire logic                       i_rst,
  // Forwarded access from the bank.
  input  wire logic                       i_fwd_req,
  input  wire logic                       i_fwd_write,
  input  wire logic [sgr_pkg::ADDR_W-1:0] i_fwd_addr,
  input  wire logic [sgr_pkg::DATA_W-1:0] i_fwd_wdata,
  input  wire logic [3:0]                 i_delay,
  output logic                            o_fwd_ack,
  output logic      [sgr_pkg::DATA_W-1:0] o_fwd_rdata
);
  logic [7:0] mem [256];
  logic [3:0] cnt_r;
  logic       pend_r;

  // The answer comes i_delay plus one cycles after the strobe.
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      pend_r <= 1'b0;
      cnt_r <= 4'h0;
      o_fwd_ack <= 1'b0;
      o_fwd_rdata <= 8'h00;
      for (int i = 0; i < 256; i++)
        mem[i] <= 8'(i) ^ 8'h5c;
    end
    else if (i_fwd_req)
    begin
      pend_r <= 1'b1;
      cnt_r <= i_delay;
      o_fwd_ack <= 1'b0;
    end
    else if (pend_r && cnt_r == 4'h0)
    begin
      pend_r <= 1'b0;
      o_fwd_ack <= 1'b1;
      o_fwd_rdata <= mem[i_fwd_addr[7:0]];
      if (i_fwd_write)
        mem[i_fwd_addr[7:0]] <= i_fwd_wdata;
    end
    else
    begin
      // Outside an answer the read byte keeps changing, so stale data never matches.
      o_fwd_ack <= 1'b0;
      cnt_r <= cnt_r - 4'h1;
      o_fwd_rdata <= ~o_fwd_rdata;
    end
  end
endmodule

// ==== test/sgr_bank_tb.sv ====
// Self-checking bench of the global register bank with a page block model.
// Assumes the bank's byte access handshake and a 100 MHz core clock.
`timescale 1ns/100ps
module sgr_bank_tb;
  import sgr_pkg::*;
  // Arbitrary identification values.
  localparam logic [7:0] ID0 = 8'h6e;
  localparam logic [7:0] IDH = 8'h4d;
  localparam logic [7:0] IDL = 8'h2b;
  localparam logic [3:0] REV = 4'h3;
  logic        i_clock, i_rst, i_req, i_write, i_from_phy_serial, i_fwd_ack;
  logic        i_lookup_engine_irq, i_power_event, o_ack, o_err, o_busy, o_fwd_req;
  logic        o_fwd_write, o_soft_reset, o_power_event_pin_out, o_power_event_pin_oe, o_irq;
  logic [15:0] i_addr, o_fwd_addr;
  logic [7:0]  i_wdata, o_rdata, o_fwd_wdata, i_fwd_rdata, r;
  logic [3:0]  dly;
  logic        e;
  // Busy and forward strobe seen one edge after a request is taken.
  logic [1:0]  fwd_seen;
  int          miscompares = 0;
  int          cmp_count = 0;
  // Bits 17 and 16 mark the serial PHY path and an expected refusal.
  logic [17:0] tab [23] = '{18'h00121, 18'h00221, 18'h00321, 18'h00421, 18'h10521,
    18'h10f21, 18'h01021, 18'h03321, 18'h05521, 18'h06621, 18'h07821, 18'h07921,
    18'h07a21, 18'h07b21, 18'h11221, 18'h12721, 18'h13c21, 18'h17f21, 18'h20221,
    18'h21121, 18'h30001, 18'h30321, 18'h32021};

  sgr_bank #(.IDENT_0(ID0), .IDENT_HIGH(IDH), .IDENT_LOW(IDL), .REVISION(REV)) sgr_bank_i (
    .i_clock, .i_rst, .i_req, .i_write, .i_from_phy_serial, .i_addr, .i_wdata, .o_ack,
    .o_err, .o_busy, .o_rdata, .o_fwd_req, .o_fwd_write, .o_fwd_addr, .o_fwd_wdata,
    .i_fwd_ack, .i_fwd_rdata, .i_lookup_engine_irq, .i_power_event, .o_soft_reset,
    .o_power_event_pin_out, .o_power_event_pin_oe, .o_irq);

  sgr_page_model sgr_page_model_i (.i_clock, .i_rst, .i_fwd_req(o_fwd_req),
    .i_fwd_write(o_fwd_write), .i_fwd_addr(o_fwd_addr), .i_fwd_wdata(o_fwd_wdata),
    .i_delay(dly), .o_fwd_ack(i_fwd_ack), .o_fwd_rdata(i_fwd_rdata));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The request is taken at the second edge, so it drops there to avoid a second access.
  task automatic acc(input logic wr, input logic ser, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge i_clock);
    i_req <= 1'b1;
    i_write <= wr;
    i_from_phy_serial <= ser;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_req <= 1'b0;
    do
    begin
      @(posedge i_clock);
      n++;
      if (n == 1)
        fwd_seen = {o_busy, o_fwd_req};
    end
    while (o_ack !== 1'b1 && n < 40);
    chk(16'(n < 40), 16'h1);
    rd = o_rdata;
    er = o_err;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    acc(1'b0, 1'b0, a, 8'h00, r, e);
    chk(e, 1'b0);
    chk(r, exp);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    acc(1'b1, 1'b0, a, d, r, e);
    chk(e, 1'b0);
  endtask

  task automatic defaults();
    rd(16'h0000, ID0);
    rd(16'h0001, IDH);
    rd(16'h0002, IDL);
    rd(16'h0003, {REV, 4'h0});
    rd(16'h0006, 8'h00);
    rd(16'h0010, 8'h00);
    rd(16'h0014, 8'h00);
  endtask

  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  initial
  begin
    #200000;
    miscompares++;
    test_done();
  end

  initial
  begin
    {i_req, i_write, i_from_phy_serial, i_lookup_engine_irq, i_power_event} = 5'h00;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    dly = 4'h0;
    i_rst = 1'b1;
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    chk(o_power_event_pin_oe, 1'b0);
    defaults();
    wr(16'h0001, 8'hff);
    rd(16'h0001, IDH);
    wr(16'h0003, 8'h01);
    repeat (10) @(posedge i_clock);
    chk(o_soft_reset, 1'b1);
    rd(16'h0003, {REV, 4'h1});
    wr(16'h0006, 8'h02);
    repeat (2) @(posedge i_clock);
    chk(o_power_event_pin_oe, 1'b1);
    i_power_event <= 1'b1;
    repeat (2) @(posedge i_clock);
    chk(o_power_event_pin_out, 1'b0);
    acc(1'b0, 1'b0, 16'h0006, 8'h00, r, e);
    wr(16'h0006, r | 8'h01);
    repeat (2) @(posedge i_clock);
    chk(o_power_event_pin_out, 1'b1);
    i_lookup_engine_irq <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk(o_irq, 1'b1);
    rd(16'h0010, 8'h80);
    rd(16'h0013, 8'h00);
    wr(16'h0014, 8'h80);
    repeat (2) @(posedge i_clock);
    chk(o_irq, 1'b0);
    rd(16'h0014, 8'h80);
    rd(16'h0017, 8'h00);
    chk(o_soft_reset, 1'b1);
    rd(16'h0006, 8'h03);
    i_lookup_engine_irq <= 1'b0;
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    defaults();
    chk(o_soft_reset, 1'b0);
    // Reserved places are only read, never written.
    foreach (tab[k])
    begin
      dly <= 4'(k % 4);
      acc(1'b0, tab[k][17], tab[k][15:0], 8'h00, r, e);
      chk(e, tab[k][16]);
      chk(fwd_seen, tab[k][16] ? 16'h0 : 16'h3);
      chk(r, tab[k][16] ? 8'h00 : tab[k][7:0] ^ 8'h5c);
      if (!tab[k][16])
        chk(o_fwd_addr, tab[k][15:0]);
    end
    dly <= 4'h6;
    wr(16'h4b33, 8'ha5);
    chk(o_fwd_write, 1'b1);
    chk(fwd_seen, 16'h3);
    chk(o_fwd_wdata, 8'ha5);
    rd(16'h4b33, 8'ha5);
    test_done();
  end
endmodule
